/* dv/cpu_status_stack_addrgen_bench.sv */
`default_nettype none
module cpu_status_stack_addrgen_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, sfr_wr, sub, word, addsub, cmp, rot, rot_c, m8, m24, dv, rbank, dwr, pw;
  logic hit, wr_en, fff, bank, blk;
  logic [15:0] sfr_addr, a, b, m_hi16, divisor, imm, pval, d_addr, sp, s_addr, imm_op;
  logic [15:0] v, of, ea, sp_m;
  logic [7:0] wd, rd, m_hi8, acc, c_reg, b_reg, p_lo, p_hi, sw, cv;
  logic [16:0] ret_pc, alu_res;
  logic [8:0] s_wd;
  logic [23:0] ext;
  logic [5:0] sel, psel;
  logic [6:0] off7, pra;
  logic [33:0] r;
  logic [2:0] fl;
  int k, sum, err_total, n_compared;
  cpu_core_pkg::flag_upd_t nupd;
  cpu_core_pkg::stack_req_t sreq;
  cpu_core_pkg::addr_mode_t mode, m;
  // Awkward operands first: signed edges, word carry-out, borrow from zero.
  logic [33:0] corner [4] = '{{16'h007F, 16'h0001, 2'b00}, {16'h0080, 16'h0001, 2'b10},
    {16'hFFFF, 16'h0001, 2'b01}, {16'h0000, 16'h0001, 2'b11}};
  logic [15:0] cb [4] = '{16'hFDFF, 16'hFEFF, 16'h0000, 16'h1234};
  logic [7:0] cc [4] = '{8'h01, 8'h02, 8'h7F, 8'h00};

  cpu_status_stack_addrgen DUT (
    .I_CLK_SYS(clk), .I_ARST_N(rst_n), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr),
    .i_sfr_wdata(wd), .o_sfr_rdata(rd), .o_sfr_hit(hit), .i_alu_a(a), .i_alu_b(b),
    .i_alu_sub(sub), .i_alu_word(word), .i_alu_addsub(addsub), .i_alu_cmp(cmp),
    .i_rot(rot), .i_rot_carry(rot_c), .i_mul16x8(m8), .i_mul_hi8(m_hi8),
    .i_mul24x16(m24), .i_mul_hi16(m_hi16), .i_div(dv), .i_divisor(divisor),
    .i_ninth_upd(nupd), .i_working_register_a(acc), .i_stack_req(sreq),
    .i_ret_pc(ret_pc), .i_ret_bank(rbank), .i_mode(mode), .i_imm(imm), .i_ptr_sel(sel),
    .i_ptr_low(p_lo), .i_ptr_high(p_hi), .i_c_reg(c_reg), .i_b_reg(b_reg), .i_off7(off7),
    .i_data_wr(dwr), .o_alu_result(alu_res), .o_stack_addr(s_addr), .o_stack_wdata(s_wd),
    .o_ptr_ram_addr(pra), .o_data_addr(d_addr), .o_ext_addr(ext), .o_imm_operand(imm_op),
    .o_data_wr_en(wr_en), .o_force_ff(fff), .o_status_word(sw), .o_table_bank(bank),
    .o_stack_ptr(sp)
  );
  pointer_ram_model partner (
    .i_clk(clk), .i_wr(pw), .i_sel(psel), .i_val(pval), .i_raddr(pra),
    .o_low(p_lo), .o_high(p_hi)
  );

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  task automatic chk(input string n, logic [23:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= ad;
    wd <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  // Read data is registered, so it is looked at one edge after the address.
  task automatic reg_rd(input logic [15:0] ad, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= ad;
    @(posedge clk);
    #1;
    chk("sfr_rdata", 24'(rd), 24'(e));
    chk("sfr_hit", 24'(hit), 24'(ad inside {16'hFE06, 16'hFE0A, 16'hFE0B}));
  endtask
  // Byte operands move to the upper byte so one 16-bit sum serves both.
  function automatic logic [2:0] flags(input logic [15:0] p, q, input logic s, ww);
    logic [15:0] x, y;
    logic [16:0] t;
    logic [12:0] n;
    x = ww ? p : {p[7:0], 8'h00};
    y = ww ? q : {q[7:0], 8'h00};
    t = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    n = s ? {1'b0, x[11:0]} - {1'b0, y[11:0]} : {1'b0, x[11:0]} + {1'b0, y[11:0]};
    return {t[16], n[12], ((x[15] ^ y[15]) == s) && (t[15] != x[15])};
  endfunction
  task automatic stk(input int op);
    @(posedge clk);
    sreq <= 4'b1000 >> op;
    ret_pc <= 17'($urandom);
    rbank <= 1'($urandom);
    @(posedge clk);
    sreq <= '0;
    #1;
    chk("stack_addr", 24'(s_addr), 24'(sp_m + 16'(op % 2 == 0)));
    sp_m += 16'(op == 0 ? 1 : op == 1 ? -1 : op == 2 ? 2 : -2);
    chk("stack_ptr", 24'(sp), 24'(sp_m));
    if (op == 2) chk("call_byte", 24'(s_wd), 24'({rbank, ret_pc[7:0]}));
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // A hung run still ends through the one closing report.
  initial begin
    #1ms;
    err_total++;
    final_report();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {rst_n, sfr_wr, sub, word, addsub, cmp, rot, rot_c, m8, m24, dv, rbank, dwr, pw} = '0;
    {sfr_addr, a, b, m_hi16, divisor, imm, pval, wd, m_hi8, acc, c_reg, b_reg} = '0;
    {ret_pc, sel, psel, off7, nupd, sreq} = '0;
    mode = cpu_core_pkg::MODE_IMM8;
    void'($urandom(32'hdd1e));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(16'hFE06, 8'h00);
    reg_rd(16'hFE0A, 8'h00);
    reg_rd(16'hFE0B, 8'h00);
    reg_rd(16'hFE07, 8'h00);
    reg_wr(16'hFE06, 8'h38);
    reg_rd(16'hFE06, 8'h38);
    chk("table_bank", 24'(bank), 24'h1);
    reg_wr(16'hFE06, 8'h00);
    reg_wr(16'hFE0A, 8'hFF);
    reg_wr(16'hFE0B, 8'h00);
    sp_m = 16'h00FF;
    for (int i = 0; i < 6; i++) stk(i < 2 ? 0 : i < 3 ? 2 : i < 4 ? 3 : 1);
    for (int i = 0; i < 64; i++) begin
      k = (i < 4) ? 0 : i % 6;
      r = (i < 4) ? corner[i] : 34'({$urandom, $urandom});
      r[1] = r[1] | (k == 1);
      @(posedge clk);
      {a, b, sub, word} <= r;
      {addsub, cmp, rot, m8, m24, dv} <= 6'b100000 >> k;
      rot_c <= 1'($urandom);
      m_hi8 <= 8'($urandom % 4);
      m_hi16 <= 16'($urandom % 4);
      divisor <= 16'($urandom % 4);
      acc <= 8'($urandom);
      nupd <= 8'($urandom % 4);
      @(posedge clk);
      {addsub, cmp, rot, m8, m24, dv} <= '0;
      #1;
      fl = flags(a, b, sub, word);
      case (k)
        0: chk("addsub", 24'({sw[7], sw[6], sw[2]}), 24'(fl));
        1: chk("cmp", 24'(sw[7]), 24'(fl[2]));
        2: chk("rot", 24'(sw[7]), 24'(rot_c));
        3: chk("mul_byte", 24'(sw[2]), 24'(m_hi8 != 0));
        4: chk("mul_word", 24'(sw[2]), 24'(m_hi16 != 0));
        default: chk("div", 24'(sw[2]), 24'(divisor == 0));
      endcase
      chk("parity", 24'(sw[0]), 24'(^acc));
      ea = sub ? a - b : a + b;
      if (k == 0) chk("alu_result", 24'(alu_res), 24'({fl[2], word ? ea : {8'h00, ea[7:0]}}));
      if (nupd.upd_ninth) chk("ninth", 24'(sw[1]), 24'(nupd.ninth));
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      mode <= cpu_core_pkg::addr_mode_t'(i);
      imm <= 16'($urandom);
      @(posedge clk);
      #1;
      chk("imm", 24'(imm_op), 24'(i ? imm : imm[7:0]));
    end
    // Pointer modes: base area decides confinement whatever the offset does.
    for (int i = 0; i < 40; i++) begin
      m = (i < 4) ? cpu_core_pkg::addr_mode_t'(i == 2 ? 4 : i == 3 ? 2 : 3)
        : cpu_core_pkg::addr_mode_t'(2 + $urandom % 3);
      v = (i < 4) ? cb[i] : 16'($urandom) | (i % 3 == 1 ? 16'hFE00 : 16'h0000);
      cv = (i < 4) ? cc[i] : 8'($urandom);
      @(posedge clk);
      pw <= 1'b1;
      psel <= (m == cpu_core_pkg::MODE_PTR0_OFF) ? 6'h00 : 6'($urandom);
      pval <= v;
      @(posedge clk);
      pw <= 1'b0;
      {mode, sel, c_reg, off7, dwr, b_reg} <= {m, psel, cv, cv[6:0], 1'($urandom), 8'($urandom)};
      @(posedge clk);
      #1;
      of = (m == cpu_core_pkg::MODE_PTR_C) ? 16'($signed(cv)) :
        (m == cpu_core_pkg::MODE_PTR0_OFF) ? 16'($signed(cv[6:0])) : 16'h0000;
      sum = int'(v) + int'($signed(of));
      blk = (v < 16'hFE00) && (sum < 0 || sum > 'hFDFF);
      ea = (v >= 16'hFE00) ? {v[15:8], 8'(sum)} : 16'(sum);
      chk("ptr_ram_addr", 24'(pra), 24'({sel, 1'b0}));
      chk("force_ff", 24'(fff), 24'(blk));
      chk("wr_en", 24'(wr_en), 24'(dwr && !blk));
      if (!blk) chk("data_addr", 24'(d_addr), 24'(ea));
      if (v < 16'hFE00 && !blk) chk("ext_addr", ext, {b_reg, ea});
    end
    final_report();
  end
endmodule
`default_nettype wire

/* dv/cpu_status_stack_addrgen_checker.sv */
`default_nettype none
// ****************************************************************
// Port-level checks on the status flags and the stack pointer.
// ****************************************************************
module cpu_status_stack_addrgen_checker (
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  input wire logic [15:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_alu_addsub,
  input wire logic i_alu_cmp,
  input wire logic i_rot,
  input wire logic i_rot_carry,
  input wire logic i_mul16x8,
  input wire logic [7:0] i_mul_hi8,
  input wire logic i_mul24x16,
  input wire logic i_div,
  input wire logic [15:0] i_divisor,
  input wire cpu_core_pkg::flag_upd_t i_ninth_upd,
  input wire logic [7:0] i_working_register_a,
  input wire cpu_core_pkg::stack_req_t i_stack_req,
  input wire logic [16:0] i_ret_pc,
  input wire logic i_ret_bank,
  input wire logic [7:0] o_status_word,
  input wire logic [15:0] o_stack_ptr,
  input wire logic [15:0] o_stack_addr,
  input wire logic [8:0] o_stack_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);
  logic [8:0] ret_low;
  logic any_upd;
  // Bank bit with the low counter byte, as a call stores it first.
  assign ret_low = {i_ret_bank, i_ret_pc[7:0]};
  // Every source that may move a flag in bits 7 to 1; anything else must leave those bits alone.
  assign any_upd = i_alu_addsub | i_alu_cmp | i_rot | i_mul16x8 | i_mul24x16 | i_div
    | i_ninth_upd.upd_carry | i_ninth_upd.upd_nibble | i_ninth_upd.upd_ninth
    | (i_sfr_wr && i_sfr_addr == cpu_core_pkg::ADDR_STATUS_WORD);
  a_parity_tracks_acc: assert property (
    $past(I_ARST_N) |-> o_status_word[0] == ^$past(i_working_register_a))
    else $error("parity bit does not follow the accumulator");
  a_rot_sets_carry: assert property (
    i_rot |=> o_status_word[7] == $past(i_rot_carry))
    else $error("rotate carry not taken");
  a_mul_upper_ovf: assert property (
    i_mul16x8 |=> o_status_word[2] == ($past(i_mul_hi8) != 8'h00))
    else $error("multiply overflow wrong");
  a_div_zero_ovf: assert property (
    i_div && i_divisor == 16'h0000 |=> o_status_word[2])
    else $error("zero divisor without overflow");
  a_push_pre_inc: assert property (
    i_stack_req.push |=> o_stack_ptr == $past(o_stack_ptr) + 16'h0001
      && o_stack_addr == o_stack_ptr)
    else $error("push did not pre-increment");
  a_call_two_bytes: assert property (
    i_stack_req.call |=> o_stack_ptr == $past(o_stack_ptr) + 16'h0002
      && o_stack_addr == $past(o_stack_ptr) + 16'h0001 && o_stack_wdata == $past(ret_low))
    else $error("call stacking wrong");
  a_ret_two_bytes: assert property (
    i_stack_req.ret |=> o_stack_ptr == $past(o_stack_ptr) - 16'h0002
      && o_stack_addr == $past(o_stack_ptr))
    else $error("return unstacking wrong");
  a_flags_hold_idle: assert property (
    !any_upd |=> $stable(o_status_word[7:1]))
    else $error("status flag moved without cause");
endmodule
bind cpu_status_stack_addrgen cpu_status_stack_addrgen_checker u_chk (.*);
`default_nettype wire

/* dv/pointer_ram_model.sv */
`default_nettype none
// ****************************************************************
// Pointer register RAM as the sequencer side holds it.
// ****************************************************************
module pointer_ram_model (
  input wire logic i_clk,
  input wire logic i_wr,
  input wire logic [5:0] i_sel,
  input wire logic [15:0] i_val,
  input wire logic [6:0] i_raddr,
  output logic [7:0] o_low,
  output logic [7:0] o_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:127];
  // Low byte at the even address and the high byte just above it.
  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem[{i_sel, 1'b0}] <= i_val[7:0];
      mem[{i_sel, 1'b1}] <= i_val[15:8];
    end
  end
  // Reads answer at once, as the core RAM does within one cycle.
  assign o_low = mem[i_raddr];
  assign o_high = mem[i_raddr | 7'h01];
endmodule
`default_nettype wire

/* src/addr_confine.sv */
`default_nettype none
// ******************************************************************
// Offset address forming with area confinement.
// ******************************************************************
module addr_confine (
  input wire logic [15:0] i_base,
  input wire logic [15:0] i_offset,
  output logic [15:0] o_addr,
  output logic o_blocked
);
  logic [15:0] sum;
  cpu_core_pkg::area_t base_area;

  assign sum = i_base + i_offset;
  assign base_area = cpu_core_pkg::area_of(i_base); // RULE19
  // The base alone decides the area; a RAM base leaving RAM is blocked.
  assign o_blocked = (base_area == cpu_core_pkg::AREA_RAM) &&
                     (cpu_core_pkg::area_of(sum) != cpu_core_pkg::AREA_RAM); // RULE20
  // SFR and reserved bases keep only the low byte of the sum.
  assign o_addr = (base_area == cpu_core_pkg::AREA_RAM) ? sum :
                  {i_base[15:8], sum[7:0]}; // RULE21
endmodule
`default_nettype wire

/* src/cpu_core_pkg.sv */
// Overview of operation
// RULE1: Status word sits at FE06H and clears to zero on reset.
// RULE2: Bit 7 carry sets on add carry, subtract, compare or rotate borrow.
// RULE3: Bit 6 nibble carry comes from bit 3, high byte bit 3 for words.
// RULE4: Bits 5 and 4 are plain user storage with no hardware effect.
// RULE5: Bit 3 picks the ROM bank for word table reads.
// RULE6: Bit 2 overflow sets when a signed add or subtract gives a wrong sign.
// RULE7: Overflow sets when the upper product bits of a multiply are nonzero.
// RULE8: Overflow sets when a division has a zero divisor.
// RULE9: Bit 1 carries the ninth bit of data RAM 0000H to FDFFH.
// RULE10: Bit 0 always shows the odd parity of the working accumulator.
// RULE11: Stack pointer low byte at FE0A, high byte at FE0B, both reset zero.
// RULE12: Stack pointer increments before each push, decrements after each pop.
// RULE13: A call pushes bank bit with low byte, then the high byte; the code writes only the bank and low byte at SP+1.
// RULE14: A return pops the high byte, then bank bit with low byte; the code presents only address SP and moves SP down by 2.
// RULE15: RAM 00H to 7FH holds sixty-four 16-bit pointers, low byte first.
// RULE16: Pointer-indirect mode uses the selected pointer as the address.
// RULE17: Pointer-plus-C mode adds the sign-extended C register to the pointer.
// RULE18: Immediate operands are one byte or one 16-bit word.
// RULE19: Data space has reserved, SFR and RAM areas; the base fixes the area.
// RULE20: A RAM base whose sum leaves the RAM area reads back 0FFH.
// RULE21: An SFR base keeps the low sum byte and wraps within FE00H to FEFFH.
// RULE22: Pointer-zero mode adds a signed 7-bit offset with the same confinement.
// RULE23: Saved counter puts bank and low bits at SP+1, upper nine at SP+2; the code writes only the SP+1 entry.
// RULE24: External accesses use the B register as address bits 23 to 16.
// RULE25: Writes whose adjusted address leaves a RAM base are discarded.
// RULE26: Flags not affected by an instruction class keep their value.
`default_nettype none
package cpu_core_pkg;
  // ****************************************************************
  // Register map and reset values.
  // ****************************************************************
  localparam logic [15:0] ADDR_STATUS_WORD = 16'hFE06;
  localparam logic [15:0] ADDR_SP_LOW = 16'hFE0A;
  localparam logic [15:0] ADDR_SP_HIGH = 16'hFE0B;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] FORCED_READ = 8'hFF;

  // ****************************************************************
  // Status word bit positions.
  // ****************************************************************
  localparam int BIT_CARRY = 7;
  localparam int BIT_NIBBLE = 6;
  localparam int BIT_USER_UP = 5;
  localparam int BIT_USER_LO = 4;
  localparam int BIT_BANK = 3;
  localparam int BIT_ARITH_ERR = 2;
  localparam int BIT_NINTH = 1;
  localparam int BIT_PARITY = 0;

  // ****************************************************************
  // Data space areas.
  // ****************************************************************
  localparam logic [15:0] SFR_BASE = 16'hFE00;
  localparam logic [15:0] RSV_BASE = 16'hFF00;
  localparam logic [6:0] PTR_AREA_TOP = 7'h7F;

  // Addressing modes that the sequencer can request.
  typedef enum logic [2:0] {
    MODE_IMM8, MODE_IMM16, MODE_PTR, MODE_PTR_C, MODE_PTR0_OFF
  } addr_mode_t;

  // Data space area of an address.
  typedef enum logic [1:0] {AREA_RAM, AREA_SFR, AREA_RSV} area_t;

  // Flag update request from the ALU for one instruction.
  typedef struct packed {
    logic upd_carry;
    logic carry;
    logic upd_nibble;
    logic nibble;
    logic upd_arith;
    logic arith_err;
    logic upd_ninth;
    logic ninth;
  } flag_upd_t;

  // Stack operation request from the sequencer.
  typedef struct packed {
    logic push;
    logic pop;
    logic call;
    logic ret;
  } stack_req_t;

  // Classify an address into its area.
  function automatic area_t area_of(input logic [15:0] a);
    if (a >= RSV_BASE) begin
      return AREA_RSV;
    end else if (a >= SFR_BASE) begin
      return AREA_SFR;
    end
    return AREA_RAM;
  endfunction
endpackage
`default_nettype wire

/* src/cpu_status_stack_addrgen.sv */
`default_nettype none
// ******************************************************************
// Status word, stack pointer and data address generation.
// ******************************************************************
module cpu_status_stack_addrgen (
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  // Special function register port from the sequencer.
  input wire logic [15:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // Arithmetic operands and class controls.
  input wire logic [15:0] i_alu_a,
  input wire logic [15:0] i_alu_b,
  input wire logic i_alu_sub,
  input wire logic i_alu_word,
  input wire logic i_alu_addsub,
  input wire logic i_alu_cmp,
  input wire logic i_rot,
  input wire logic i_rot_carry,
  input wire logic i_mul16x8,
  input wire logic [7:0] i_mul_hi8,
  input wire logic i_mul24x16,
  input wire logic [15:0] i_mul_hi16,
  input wire logic i_div,
  input wire logic [15:0] i_divisor,
  input wire cpu_core_pkg::flag_upd_t i_ninth_upd,
  input wire logic [7:0] i_working_register_a,
  // Stack requests.
  input wire cpu_core_pkg::stack_req_t i_stack_req,
  input wire logic [16:0] i_ret_pc,
  input wire logic i_ret_bank,
  // Addressing.
  input wire cpu_core_pkg::addr_mode_t i_mode,
  input wire logic [15:0] i_imm,
  input wire logic [5:0] i_ptr_sel,
  input wire logic [7:0] i_ptr_low,
  input wire logic [7:0] i_ptr_high,
  input wire logic [7:0] i_c_reg,
  input wire logic [7:0] i_b_reg,
  input wire logic [6:0] i_off7,
  input wire logic i_data_wr,
  output logic [16:0] o_alu_result,
  output logic [15:0] o_stack_addr,
  output logic [8:0] o_stack_wdata,
  output logic [6:0] o_ptr_ram_addr,
  output logic [15:0] o_data_addr,
  output logic [23:0] o_ext_addr,
  output logic [15:0] o_imm_operand,
  output logic o_data_wr_en,
  output logic o_force_ff,
  output logic [7:0] o_status_word,
  output logic o_table_bank,
  output logic [15:0] o_stack_ptr
);
  // ****************************************************************
  // Status word storage.
  // ****************************************************************
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [15:0] stack_ptr_r;
  logic [15:0] stack_ptr_nxt;
  logic [15:0] addr_r;
  logic [23:0] ext_addr_r;
  logic force_r;
  logic wr_en_r;
  logic [15:0] stack_addr_r;
  logic [8:0] stack_wdata_r;
  logic [7:0] rdata_r;
  logic [16:0] result_r;

  logic [15:0] alu_res;
  logic alu_carry;
  logic alu_nibble;
  logic alu_ovf;
  logic wr_status;
  logic wr_sp_low;
  logic wr_sp_high;
  logic carry_upd;
  logic carry_val;
  logic arith_upd;
  logic arith_val;
  logic parity;
  logic [15:0] ptr_value;
  logic [15:0] offset;
  logic [15:0] conf_addr;
  logic conf_blocked;
  logic use_offset;

  flag_unit u_flag (
    .i_op_a(i_alu_a),
    .i_op_b(i_alu_b),
    .i_sub(i_alu_sub),
    .i_word(i_alu_word),
    .o_result(alu_res),
    .o_carry(alu_carry),
    .o_nibble(alu_nibble),
    .o_ovf(alu_ovf)
  );

  // Register decode on the documented SFR addresses.
  assign wr_status = i_sfr_wr && (i_sfr_addr == cpu_core_pkg::ADDR_STATUS_WORD); // RULE1
  assign wr_sp_low = i_sfr_wr && (i_sfr_addr == cpu_core_pkg::ADDR_SP_LOW); // RULE11
  assign wr_sp_high = i_sfr_wr && (i_sfr_addr == cpu_core_pkg::ADDR_SP_HIGH); // RULE11
  assign o_sfr_hit = (i_sfr_addr == cpu_core_pkg::ADDR_STATUS_WORD) ||
                     (i_sfr_addr == cpu_core_pkg::ADDR_SP_LOW) ||
                     (i_sfr_addr == cpu_core_pkg::ADDR_SP_HIGH);

  // Carry comes from add, subtract, compare, rotate or a carry update request; other classes hold it.
  assign carry_upd = i_alu_addsub || i_alu_cmp || i_rot || i_ninth_upd.upd_carry; // RULE26
  assign carry_val = i_rot ? i_rot_carry :
                     (i_alu_addsub || i_alu_cmp) ? alu_carry : i_ninth_upd.carry; // RULE2
  // Overflow sources are signed add or subtract, multiplies and division.
  assign arith_upd = i_alu_addsub || i_mul16x8 || i_mul24x16 || i_div; // RULE26
  assign arith_val = (i_alu_addsub && alu_ovf) || // RULE6
                     (i_mul16x8 && (i_mul_hi8 != 8'h00)) || // RULE7
                     (i_mul24x16 && (i_mul_hi16 != 16'h0000)) || // RULE7
                     (i_div && (i_divisor == 16'h0000)); // RULE8
  assign parity = ^i_working_register_a; // RULE10

  // Next status word: software write first, then hardware flag updates win.
  always_comb begin
    status_nxt = wr_status ? i_sfr_wdata : status_r; // RULE4
    if (carry_upd) begin
      status_nxt[cpu_core_pkg::BIT_CARRY] = carry_val;
    end
    if (i_alu_addsub) begin
      status_nxt[cpu_core_pkg::BIT_NIBBLE] = alu_nibble; // RULE3
    end else if (i_ninth_upd.upd_nibble) begin
      status_nxt[cpu_core_pkg::BIT_NIBBLE] = i_ninth_upd.nibble;
    end
    if (arith_upd) begin
      status_nxt[cpu_core_pkg::BIT_ARITH_ERR] = arith_val;
    end
    if (i_ninth_upd.upd_ninth) begin
      status_nxt[cpu_core_pkg::BIT_NINTH] = i_ninth_upd.ninth; // RULE9
    end
    status_nxt[cpu_core_pkg::BIT_PARITY] = parity; // RULE10
  end

  // Stack pointer: pre-increment on a push, post-decrement on a pop.
  always_comb begin
    stack_ptr_nxt = stack_ptr_r;
    if (wr_sp_low) begin
      stack_ptr_nxt[7:0] = i_sfr_wdata;
    end
    if (wr_sp_high) begin
      stack_ptr_nxt[15:8] = i_sfr_wdata;
    end
    if (i_stack_req.call) begin
      stack_ptr_nxt = stack_ptr_r + 16'h0002; // RULE23
    end else if (i_stack_req.ret) begin
      stack_ptr_nxt = stack_ptr_r - 16'h0002; // RULE14
    end else if (i_stack_req.push) begin
      stack_ptr_nxt = stack_ptr_r + 16'h0001; // RULE12
    end else if (i_stack_req.pop) begin
      stack_ptr_nxt = stack_ptr_r - 16'h0001; // RULE12
    end
  end

  // ****************************************************************
  // Address generation.
  // ****************************************************************
  // The pointer register lives at RAM 2n (low) and 2n+1 (high).
  assign o_ptr_ram_addr = {i_ptr_sel, 1'b0}; // RULE15
  assign ptr_value = {i_ptr_high, i_ptr_low}; // RULE16
  assign offset = (i_mode == cpu_core_pkg::MODE_PTR_C) ? {{8{i_c_reg[7]}}, i_c_reg} : // RULE17
                  {{9{i_off7[6]}}, i_off7}; // RULE22
  assign use_offset = (i_mode == cpu_core_pkg::MODE_PTR_C) ||
                      (i_mode == cpu_core_pkg::MODE_PTR0_OFF);

  addr_confine u_confine (
    .i_base(ptr_value),
    .i_offset(offset),
    .o_addr(conf_addr),
    .o_blocked(conf_blocked)
  );

  // Immediate operands are a byte or a whole word.
  assign o_imm_operand = (i_mode == cpu_core_pkg::MODE_IMM8) ? {8'h00, i_imm[7:0]} :
                         i_imm; // RULE18

  // ****************************************************************
  // Registers.
  // ****************************************************************
  // Status word and stack pointer clear on reset.
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      status_r <= cpu_core_pkg::STATUS_RESET; // RULE1
      stack_ptr_r <= cpu_core_pkg::SP_RESET; // RULE11
    end else begin
      status_r <= status_nxt;
      stack_ptr_r <= stack_ptr_nxt;
    end
  end

  // Operand address, external address and write permission.
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      addr_r <= 16'h0000;
      ext_addr_r <= 24'h000000;
      force_r <= 1'b0;
      wr_en_r <= 1'b0;
    end else begin
      addr_r <= use_offset ? conf_addr : ptr_value;
      ext_addr_r <= {i_b_reg, use_offset ? ptr_value + offset : ptr_value}; // RULE24
      force_r <= use_offset && conf_blocked; // RULE20
      wr_en_r <= i_data_wr && !(use_offset && conf_blocked); // RULE25
    end
  end

  // Stack address and data for the current push or pop.
  // A call writes bank with low PC at SP+1; no write of the upper nine bits to SP+2 is made.
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      stack_addr_r <= 16'h0000;
      stack_wdata_r <= 9'h000;
    end else if (i_stack_req.call) begin
      stack_addr_r <= stack_ptr_r + 16'h0001; // RULE13
      stack_wdata_r <= {i_ret_bank, i_ret_pc[7:0]}; // RULE23
    end else if (i_stack_req.push) begin
      stack_addr_r <= stack_ptr_r + 16'h0001; // RULE12
      stack_wdata_r <= {status_r[cpu_core_pkg::BIT_NINTH], i_sfr_wdata};
    end else if (i_stack_req.pop || i_stack_req.ret) begin
      stack_addr_r <= stack_ptr_r; // RULE14
      stack_wdata_r <= 9'h000;
    end
  end

  // Register read data and arithmetic result.
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_r <= 8'h00;
      result_r <= 17'h00000;
    end else begin
      rdata_r <= (i_sfr_addr == cpu_core_pkg::ADDR_STATUS_WORD) ? status_r :
                 (i_sfr_addr == cpu_core_pkg::ADDR_SP_LOW) ? stack_ptr_r[7:0] :
                 (i_sfr_addr == cpu_core_pkg::ADDR_SP_HIGH) ? stack_ptr_r[15:8] : 8'h00;
      result_r <= {alu_carry, alu_res};
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign o_sfr_rdata = rdata_r;
  assign o_alu_result = result_r;
  assign o_stack_addr = stack_addr_r;
  assign o_stack_wdata = stack_wdata_r;
  assign o_data_addr = addr_r;
  assign o_ext_addr = ext_addr_r;
  assign o_data_wr_en = wr_en_r;
  assign o_force_ff = force_r;
  assign o_status_word = status_r;
  assign o_table_bank = status_r[cpu_core_pkg::BIT_BANK]; // RULE5
  assign o_stack_ptr = stack_ptr_r;
endmodule
`default_nettype wire

/* src/flag_unit.sv */
`default_nettype none
// ******************************************************************
// Combinational carry, nibble carry and overflow generation.
// ******************************************************************
module flag_unit (
  input wire logic [15:0] i_op_a,
  input wire logic [15:0] i_op_b,
  input wire logic i_sub,
  input wire logic i_word,
  output logic [15:0] o_result,
  output logic o_carry,
  output logic o_nibble,
  output logic o_ovf
);
  logic [16:0] sum;
  logic [15:0] b_eff;
  logic [4:0] nib_lo;
  logic [4:0] nib_hi;
  logic [8:0] byte_sum;
  logic sign_a;
  logic sign_b;
  logic sign_r;

  // Subtraction is add of the inverted operand plus one; borrow is inverted carry.
  assign b_eff = i_sub ? ~i_op_b : i_op_b;
  assign sum = {1'b0, i_op_a} + {1'b0, b_eff} + {16'h0000, i_sub};
  assign byte_sum = {1'b0, i_op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, i_sub};
  assign o_result = i_word ? sum[15:0] : {8'h00, byte_sum[7:0]};
  assign o_carry = (i_word ? sum[16] : byte_sum[8]) ^ i_sub; // RULE2
  // Word operations take the nibble carry from bit 3 of the high byte.
  assign nib_lo = {1'b0, i_op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_sub};
  assign nib_hi = {1'b0, i_op_a[11:8]} + {1'b0, b_eff[11:8]} +
                  {4'h0, sum[8] ^ i_op_a[8] ^ b_eff[8]};
  assign o_nibble = (i_word ? nib_hi[4] : nib_lo[4]) ^ i_sub; // RULE3
  // Overflow when both effective operands share a sign the result lacks.
  assign sign_a = i_word ? i_op_a[15] : i_op_a[7];
  assign sign_b = i_word ? b_eff[15] : b_eff[7];
  assign sign_r = i_word ? sum[15] : byte_sum[7];
  assign o_ovf = (sign_a == sign_b) && (sign_r != sign_a); // RULE6
endmodule
`default_nettype wire
